// [scs_clock_select.v]
// Strap-latched clock synthesiser core with APB control and status
//
// Functional notes
// - Sample three frequency straps at power-up; they choose host, memory, PCI rates.
// - After sampling, the frequency bit one pin is a never-stopped PCI clock.
// - Latch the mode strap at power-up from the 24 MHz output pin.
// - Mode 1: shared pin drives memory clock; mode 0: active-low host stop input.
// - Mode 1: second pin drives memory clock; mode 0: active-low PCI stop input.
// - Latch host buffer voltage strap from reference pin; high 2.5V, low 3.3V.
// - Memory clocks run at the host clock frequency of the selected code.
// - Slow variant table: host 60 to 100 MHz with its PCI/AGP fractions.
// - Fast variant table: host 66.8 to 133.3 MHz with its PCI/AGP values.
// - Reference outputs stay at 14.318 MHz for every select code.
// - Two AGP outputs run at the AGP rate of the selected code.
// - Start/stop waits a free PCI rising edge, then a falling edge.
// - Host stop holds host and AGP low; PCI stop holds PCI low.
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_clock_select #(
  parameter FAST_VARIANT = 0
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SCS_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // USB clock pin, strap for frequency bit 0
  input wire freqSelectBit0PinIn,
  output reg freqSelectBit0PinOut,
  output reg freqSelectBit0PinOe_n,
  // Free-running PCI clock pin, strap for frequency bit 1
  input wire freqSelectBit1PinIn,
  output reg freqSelectBit1PinOut,
  output reg freqSelectBit1PinOe_n,
  // First PCI clock pin, strap for frequency bit 2
  input wire freqSelectBit2PinIn,
  output reg freqSelectBit2PinOut,
  output reg freqSelectBit2PinOe_n,
  // First reference clock pin, strap for host buffer voltage
  input wire refVoltPinIn,
  output reg refVoltPinOut,
  output reg refVoltPinOe_n,
  // Super I/O clock pin, strap for mode
  input wire modePinIn,
  output reg modePinOut,
  output reg modePinOe_n,
  // Memory clock pin or active-low host stop input
  input wire memHostStopPinIn,
  output reg memHostStopPinOut,
  output reg memHostStopPinOe_n,
  // Memory clock pin or active-low PCI stop input
  input wire memPciStopPinIn,
  output reg memPciStopPinOut,
  output reg memPciStopPinOe_n,
  // Dedicated clock outputs
  output reg [3:0] hostClockOut,
  output reg [9:0] memClockOut,
  output reg [1:0] agpClockOut,
  output reg [3:0] pciClockOut,
  output reg referenceClockOut1,
  // Latched host buffer supply select, 1 selects 2.5V
  output reg hostBufferVoltageSelect
);

  // ----------------------------------------------------------------
  // Frequency tables
  // ----------------------------------------------------------------
  function [`SCS_NCO_W-1:0] hostKhz;
    input [2:0] code;
    input fast;
    begin
      case ({fast, code})
        4'h0: hostKhz = `SCS_KHZ_60000;
        4'h1: hostKhz = `SCS_KHZ_66800;
        4'h2: hostKhz = `SCS_KHZ_68500;
        4'h3: hostKhz = `SCS_KHZ_75000;
        4'h4: hostKhz = `SCS_KHZ_75000;
        4'h5: hostKhz = `SCS_KHZ_83300;
        4'h6: hostKhz = `SCS_KHZ_90000;
        4'h7: hostKhz = `SCS_KHZ_100000;
        4'h8: hostKhz = `SCS_KHZ_112000;
        4'h9: hostKhz = `SCS_KHZ_66800;
        4'hA: hostKhz = `SCS_KHZ_124000;
        4'hB: hostKhz = `SCS_KHZ_75000;
        4'hC: hostKhz = `SCS_KHZ_133300;
        4'hD: hostKhz = `SCS_KHZ_83300;
        4'hE: hostKhz = `SCS_KHZ_95250;
        default: hostKhz = `SCS_KHZ_100200;
      endcase
    end
  endfunction

  function [`SCS_NCO_W-1:0] pciKhz;
    input [2:0] code;
    input fast;
    begin
      case ({fast, code})
        4'h0: pciKhz = `SCS_KHZ_30000;
        4'h1: pciKhz = `SCS_KHZ_33400;
        4'h2: pciKhz = `SCS_KHZ_34250;
        4'h3: pciKhz = `SCS_KHZ_37500;
        4'h4: pciKhz = `SCS_KHZ_32000;
        4'h5: pciKhz = `SCS_KHZ_33300;
        4'h6: pciKhz = `SCS_KHZ_30000;
        4'h7: pciKhz = `SCS_KHZ_33300;
        4'h8: pciKhz = `SCS_KHZ_37300;
        4'h9: pciKhz = `SCS_KHZ_33400;
        4'hA: pciKhz = `SCS_KHZ_31000;
        4'hB: pciKhz = `SCS_KHZ_37500;
        4'hC: pciKhz = `SCS_KHZ_33300;
        4'hD: pciKhz = `SCS_KHZ_33300;
        4'hE: pciKhz = `SCS_KHZ_31750;
        default: pciKhz = `SCS_KHZ_33400;
      endcase
    end
  endfunction

  function [`SCS_NCO_W-1:0] agpKhz;
    input [2:0] code;
    input fast;
    begin
      case ({fast, code})
        4'h0: agpKhz = `SCS_KHZ_60000;
        4'h1: agpKhz = `SCS_KHZ_66800;
        4'h2: agpKhz = `SCS_KHZ_68500;
        4'h3: agpKhz = `SCS_KHZ_75000;
        4'h4: agpKhz = `SCS_KHZ_64000;
        4'h5: agpKhz = `SCS_KHZ_66600;
        4'h6: agpKhz = `SCS_KHZ_60000;
        4'h7: agpKhz = `SCS_KHZ_66600;
        4'h8: agpKhz = `SCS_KHZ_74700;
        4'h9: agpKhz = `SCS_KHZ_66800;
        4'hA: agpKhz = `SCS_KHZ_62000;
        4'hB: agpKhz = `SCS_KHZ_75000;
        4'hC: agpKhz = `SCS_KHZ_66600;
        4'hD: agpKhz = `SCS_KHZ_66600;
        4'hE: agpKhz = `SCS_KHZ_63500;
        default: agpKhz = `SCS_KHZ_66800;
      endcase
    end
  endfunction

  localparam FAST_BIT = (FAST_VARIANT != 0) ? 1'b1 : 1'b0;
  localparam NGEN = 6;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [6:0] pinRaw = {memPciStopPinIn, memHostStopPinIn, modePinIn, refVoltPinIn,
                       freqSelectBit2PinIn, freqSelectBit1PinIn, freqSelectBit0PinIn};
  reg [6:0] pinMeta_r;
  reg [6:0] pinSync_r;

  always @(posedge ref_clk) begin
    pinMeta_r <= pinRaw;
    pinSync_r <= pinMeta_r;
  end

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  reg latched_r;
  reg [2:0] freqCode_r;
  reg mode_r;
  reg volt_r;

  // Pins stay released during reset, so the synchronised level is the strap
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      latched_r <= 1'b0;
      freqCode_r <= `SCS_CODE_RST;
      mode_r <= `SCS_MODE_RST;
      volt_r <= `SCS_VOLT_RST;
    end else if (!latched_r) begin
      latched_r <= 1'b1;
      freqCode_r <= pinSync_r[2:0];
      volt_r <= pinSync_r[3];
      mode_r <= pinSync_r[4];
    end
  end

  // ----------------------------------------------------------------
  // Control register and stop requests
  // ----------------------------------------------------------------
  reg [`SCS_CTRL_W-1:0] ctrl_r;
  wire hostStop = latched_r & ~mode_r & ~pinSync_r[5];
  wire pciStop = latched_r & ~mode_r & ~pinSync_r[6];

  // ----------------------------------------------------------------
  // Synthesisers: host, PCI, AGP, reference, USB, super I/O
  // ----------------------------------------------------------------
  wire [`SCS_NCO_W-1:0] hostStep = hostKhz(freqCode_r, FAST_BIT);
  wire [NGEN*`SCS_NCO_W-1:0] steps = {`SCS_KHZ_SIO24, `SCS_KHZ_USB48, `SCS_KHZ_REF,
                                      agpKhz(freqCode_r, FAST_BIT),
                                      pciKhz(freqCode_r, FAST_BIT), hostStep};
  wire [NGEN-1:0] nco;

  genvar gi;
  generate
    for (gi = 0; gi < NGEN; gi = gi + 1) begin : gen_nco
      scs_nco #(
        .W(`SCS_NCO_W),
        .MODULUS(`SCS_REF_KHZ),
        .HALF(`SCS_REF_HALF)
      ) u_nco (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .step(steps[gi*`SCS_NCO_W +: `SCS_NCO_W]),
        .clkOut(nco[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Glitch-free start/stop of host, AGP and PCI groups
  // ----------------------------------------------------------------
  // Group 0 host, group 1 AGP, group 2 stoppable PCI
  wire [2:0] grpClk = {nco[1], nco[2], nco[0]};
  wire [2:0] grpWant = {~pciStop & ctrl_r[`SCS_CTRL_PCI],
                        ~hostStop & ctrl_r[`SCS_CTRL_AGP],
                        ~hostStop & ctrl_r[`SCS_CTRL_HOST]};
  reg [2:0] grpRun_r;
  reg [2:0] grpArmed_r;
  reg [2:0] grpClkPrev_r;
  reg freePciPrev_r;
  wire freePciRise = nco[1] & ~freePciPrev_r;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      freePciPrev_r <= 1'b0;
    end else begin
      freePciPrev_r <= nco[1];
    end
  end

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gen_gate
      always @(posedge ref_clk) begin
        if (!rst_n || !latched_r) begin
          grpRun_r[gi] <= 1'b0;
          grpArmed_r[gi] <= 1'b0;
          grpClkPrev_r[gi] <= 1'b0;
        end else begin
          grpClkPrev_r[gi] <= grpClk[gi];
          if (grpArmed_r[gi] && grpClkPrev_r[gi] && !grpClk[gi]) begin
            grpRun_r[gi] <= grpWant[gi];
            grpArmed_r[gi] <= 1'b0;
          end else if (freePciRise && (grpRun_r[gi] != grpWant[gi])) begin
            grpArmed_r[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output clock registers and pin direction
  // ----------------------------------------------------------------
  wire memOn = latched_r & ctrl_r[`SCS_CTRL_MEM];
  wire refOn = latched_r & ctrl_r[`SCS_CTRL_REF];
  wire usbOn = latched_r & ctrl_r[`SCS_CTRL_USB48];
  wire sioOn = latched_r & ctrl_r[`SCS_CTRL_SIO24];
  wire hostGated = nco[0] & grpRun_r[0];
  wire agpGated = nco[2] & grpRun_r[1];
  wire pciGated = nco[1] & grpRun_r[2];

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      hostClockOut <= 4'h0;
      memClockOut <= 10'h000;
      agpClockOut <= 2'h0;
      pciClockOut <= 4'h0;
      referenceClockOut1 <= 1'b0;
      freqSelectBit0PinOut <= 1'b0;
      freqSelectBit1PinOut <= 1'b0;
      freqSelectBit2PinOut <= 1'b0;
      refVoltPinOut <= 1'b0;
      modePinOut <= 1'b0;
      memHostStopPinOut <= 1'b0;
      memPciStopPinOut <= 1'b0;
      hostBufferVoltageSelect <= `SCS_VOLT_RST;
    end else begin
      hostClockOut <= {4{hostGated}};
      memClockOut <= {10{nco[0] & memOn}};
      agpClockOut <= {2{agpGated}};
      pciClockOut <= {4{pciGated}};
      freqSelectBit2PinOut <= pciGated;
      freqSelectBit1PinOut <= nco[1] & latched_r;
      referenceClockOut1 <= nco[3] & refOn;
      refVoltPinOut <= nco[3] & refOn;
      freqSelectBit0PinOut <= nco[4] & usbOn;
      modePinOut <= nco[5] & sioOn;
      memHostStopPinOut <= nco[0] & memOn & mode_r;
      memPciStopPinOut <= nco[0] & memOn & mode_r;
      hostBufferVoltageSelect <= volt_r;
    end
  end

  // Strap pins stay released until the straps are held
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      freqSelectBit0PinOe_n <= 1'b1;
      freqSelectBit1PinOe_n <= 1'b1;
      freqSelectBit2PinOe_n <= 1'b1;
      refVoltPinOe_n <= 1'b1;
      modePinOe_n <= 1'b1;
      memHostStopPinOe_n <= 1'b1;
      memPciStopPinOe_n <= 1'b1;
    end else begin
      freqSelectBit0PinOe_n <= ~latched_r;
      freqSelectBit1PinOe_n <= ~latched_r;
      freqSelectBit2PinOe_n <= ~latched_r;
      refVoltPinOe_n <= ~latched_r;
      modePinOe_n <= ~latched_r;
      memHostStopPinOe_n <= ~(latched_r & mode_r);
      memPciStopPinOe_n <= ~(latched_r & mode_r);
    end
  end

  // ----------------------------------------------------------------
  // APB slave: read data captured in setup, zero-wait access
  // ----------------------------------------------------------------
  wire apbSetup = psel & ~penable;
  wire apbWrite = psel & penable & pwrite;
  assign pready = psel & penable;

  reg [31:0] statusWord;
  always @* begin
    statusWord = 32'h0000_0000;
    statusWord[`SCS_ST_CODE_LSB +: 3] = freqCode_r;
    statusWord[`SCS_ST_MODE] = mode_r;
    statusWord[`SCS_ST_VOLT] = volt_r;
    statusWord[`SCS_ST_LATCHED] = latched_r;
    statusWord[`SCS_ST_RUN_LSB +: 3] = grpRun_r;
    statusWord[`SCS_ST_HOSTSTOP] = hostStop;
    statusWord[`SCS_ST_PCISTOP] = pciStop;
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r <= `SCS_CTRL_RST;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      if (apbSetup) begin
        case (paddr)
          `SCS_OFS_STATUS: begin
            prdata <= statusWord;
            pslverr <= 1'b0;
          end
          `SCS_OFS_CTRL: begin
            prdata <= {{(32-`SCS_CTRL_W){1'b0}}, ctrl_r};
            pslverr <= 1'b0;
          end
          `SCS_OFS_FREQ: begin
            prdata <= {{(32-`SCS_NCO_W){1'b0}}, hostStep};
            pslverr <= 1'b0;
          end
          default: begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (apbWrite && (paddr == `SCS_OFS_CTRL)) begin
        ctrl_r <= pwdata[`SCS_CTRL_W-1:0];
      end
    end
  end

endmodule

// [scs_defs.vh]
// Constants for the strap-latched clock select block
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

// ----------------------------------------------------------------
// Register map (byte addresses on the APB)
// ----------------------------------------------------------------
`define SCS_ADDR_W 12
`define SCS_OFS_STATUS 12'h000
`define SCS_OFS_CTRL 12'h004
`define SCS_OFS_FREQ 12'h008

// ----------------------------------------------------------------
// Control register fields: per-group output enables
// ----------------------------------------------------------------
`define SCS_CTRL_W 7
`define SCS_CTRL_HOST 0
`define SCS_CTRL_MEM 1
`define SCS_CTRL_AGP 2
`define SCS_CTRL_PCI 3
`define SCS_CTRL_REF 4
`define SCS_CTRL_USB48 5
`define SCS_CTRL_SIO24 6
`define SCS_CTRL_RST 7'h7F

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SCS_ST_CODE_LSB 0
`define SCS_ST_MODE 3
`define SCS_ST_VOLT 4
`define SCS_ST_LATCHED 5
`define SCS_ST_RUN_LSB 6
`define SCS_ST_HOSTSTOP 9
`define SCS_ST_PCISTOP 10

// ----------------------------------------------------------------
// Strap reset values
// ----------------------------------------------------------------
`define SCS_CODE_RST 3'h0
`define SCS_MODE_RST 1'h1
`define SCS_VOLT_RST 1'h0

// ----------------------------------------------------------------
// Synthesiser: ref_clk rate in kHz is the accumulator modulus
// ----------------------------------------------------------------
`define SCS_NCO_W 18
`define SCS_REF_KHZ 18'h30D40
`define SCS_REF_HALF 18'h186A0

// ----------------------------------------------------------------
// Output frequencies in kHz
// ----------------------------------------------------------------
`define SCS_KHZ_60000 18'h0EA60
`define SCS_KHZ_66800 18'h104F0
`define SCS_KHZ_68500 18'h10B94
`define SCS_KHZ_75000 18'h124F8
`define SCS_KHZ_83300 18'h14564
`define SCS_KHZ_90000 18'h15F90
`define SCS_KHZ_100000 18'h186A0
`define SCS_KHZ_112000 18'h1B580
`define SCS_KHZ_124000 18'h1E460
`define SCS_KHZ_133300 18'h208B4
`define SCS_KHZ_95250 18'h17412
`define SCS_KHZ_100200 18'h18768
`define SCS_KHZ_30000 18'h07530
`define SCS_KHZ_31000 18'h07918
`define SCS_KHZ_31750 18'h07C06
`define SCS_KHZ_32000 18'h07D00
`define SCS_KHZ_33300 18'h08214
`define SCS_KHZ_33400 18'h08278
`define SCS_KHZ_34250 18'h085CA
`define SCS_KHZ_37300 18'h091B4
`define SCS_KHZ_37500 18'h0927C
`define SCS_KHZ_62000 18'h0F230
`define SCS_KHZ_63500 18'h0F80C
`define SCS_KHZ_64000 18'h0FA00
`define SCS_KHZ_66600 18'h10428
`define SCS_KHZ_74700 18'h123CC
`define SCS_KHZ_REF 18'h037EE
`define SCS_KHZ_USB48 18'h0BB80
`define SCS_KHZ_SIO24 18'h05DC0

`endif

// [scs_nco.v]
// Phase-accumulator clock source with a modulus equal to the reference rate
`timescale 1ns/1ps
module scs_nco #(
  parameter W = 18,
  parameter [W-1:0] MODULUS = 18'h30D40,
  parameter [W-1:0] HALF = 18'h186A0
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Step per cycle, in output-frequency units
  input wire [W-1:0] step,
  // Synthesised clock
  output reg clkOut
);

  reg [W-1:0] acc_r;
  wire [W:0] sum = {1'b0, acc_r} + {1'b0, step};
  wire [W:0] wrapped = sum - {1'b0, MODULUS};

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_r <= {W{1'b0}};
      clkOut <= 1'b0;
    end else begin
      if (sum >= {1'b0, MODULUS}) begin
        acc_r <= wrapped[W-1:0];
      end else begin
        acc_r <= sum[W-1:0];
      end
      clkOut <= (acc_r < HALF);
    end
  end

endmodule

// [scs_clock_select_properties.sv]
// Port-level assertions for the strap-latched clock select block
`timescale 1ns/1ps
module scs_clock_select_properties (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Strap pin enables
  input wire freqSelectBit0PinOe_n,
  input wire freqSelectBit1PinOe_n,
  input wire freqSelectBit2PinOe_n,
  input wire refVoltPinOe_n,
  input wire modePinOe_n,
  // Shared pin levels
  input wire freqSelectBit1PinOut,
  input wire freqSelectBit2PinOut,
  input wire refVoltPinIn,
  // Memory clock or stop pins
  input wire memHostStopPinIn,
  input wire memHostStopPinOut,
  input wire memHostStopPinOe_n,
  input wire memPciStopPinIn,
  input wire memPciStopPinOut,
  input wire memPciStopPinOe_n,
  // Clock outputs
  input wire [3:0] hostClockOut,
  input wire [1:0] agpClockOut,
  input wire [3:0] pciClockOut,
  input wire hostBufferVoltageSelect
);
  reg lastFree_r;
  reg [4:0] idleCnt_r;
  reg [5:0] holdHost_r;
  reg [5:0] holdPci_r;
  // --------------------------------------------------------------
  // Helper counters: free clock idle time, stop request age
  // --------------------------------------------------------------
  always @(posedge ref_clk) begin
    lastFree_r <= freqSelectBit1PinOut;
    if (!rst_n || freqSelectBit1PinOut != lastFree_r) begin
      idleCnt_r <= 5'h00;
    end else if (idleCnt_r != 5'h1F) begin
      idleCnt_r <= idleCnt_r + 5'h01;
    end
    if (!rst_n || !memHostStopPinOe_n || memHostStopPinIn) begin
      holdHost_r <= 6'h00;
    end else if (holdHost_r != 6'h3F) begin
      holdHost_r <= holdHost_r + 6'h01;
    end
    if (!rst_n || !memPciStopPinOe_n || memPciStopPinIn) begin
      holdPci_r <= 6'h00;
    end else if (holdPci_r != 6'h3F) begin
      holdPci_r <= holdPci_r + 6'h01;
    end
  end
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_pins_released: assert property (disable iff (1'b0) !rst_n |=>
    (freqSelectBit0PinOe_n && freqSelectBit1PinOe_n && freqSelectBit2PinOe_n
     && refVoltPinOe_n && modePinOe_n && memHostStopPinOe_n && memPciStopPinOe_n))
    else $error("shared pin driven during reset");
  a_straps_driven: assert property (rst_n && $past(rst_n) && $past(rst_n, 2) |->
    !(freqSelectBit0PinOe_n || freqSelectBit1PinOe_n || freqSelectBit2PinOe_n
      || refVoltPinOe_n || modePinOe_n))
    else $error("strap pin not driven after latch");
  a_mode_pair: assert property (memHostStopPinOe_n == memPciStopPinOe_n)
    else $error("stop pins disagree on mode");
  a_straps_held: assert property (
    rst_n && $past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3)
    |-> $stable(memHostStopPinOe_n) && $stable(hostBufferVoltageSelect))
    else $error("latched strap changed");
  a_volt_strap: assert property ($rose(rst_n) |-> ##3
    hostBufferVoltageSelect == $past(refVoltPinIn, 4))
    else $error("voltage select differs from strap");
  a_stop_no_mem: assert property (memHostStopPinOe_n |->
    !memHostStopPinOut && !memPciStopPinOut)
    else $error("memory clock on stop input pin");
  a_host_stopped: assert property (holdHost_r >= 6'h28 |->
    hostClockOut == 4'h0 && agpClockOut == 2'h0)
    else $error("host group runs under stop");
  a_pci_stopped: assert property (holdPci_r >= 6'h28 |->
    pciClockOut == 4'h0 && !freqSelectBit2PinOut)
    else $error("pci group runs under stop");
  a_free_runs: assert property (idleCnt_r < 5'h0C)
    else $error("free running pci clock stalled");
  c_host_stop: cover property (holdHost_r == 6'h28);
  c_pci_stop: cover property (holdPci_r == 6'h28);
  c_mem_pin: cover property ($rose(memHostStopPinOut));
endmodule

// [scs_load_model.sv]
// Board-side model: strap resistors, pull-ups and the chipset stop inputs
`timescale 1ns/1ps
module scs_load_model (
  // Device side of the shared pins
  input wire logic [6:0] pinOut,
  input wire logic [6:0] pinOe_n,
  // Levels the board applies while the device lets go
  input wire logic [6:0] level,
  // Resolved pin levels
  output logic [6:0] pinIn
);
  // Straps and pull-ups win only while the pin is released
  assign pinIn[4:0] = (pinOe_n[4:0] & level[4:0]) | (~pinOe_n[4:0] & pinOut[4:0]);
  // Chipset stop inputs once the mode strap leaves the pins undriven
  assign pinIn[6:5] = (pinOe_n[6:5] & level[6:5]) | (~pinOe_n[6:5] & pinOut[6:5]);
endmodule

// [testbench.sv]
// Self-checking bench for the strap-latched clock select block
`timescale 1ns/1ps
`include "scs_defs.vh"
module testbench;
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, prdataFast, rd, rdFast, seed = 32'h0001778B;
  logic pready, pslverr, referenceClockOut1, hostBufferVoltageSelect;
  logic [6:0] pinOut, pinOe_n, pinIn, level = 7'h7F;
  logic [9:0] smp, smpPrev = 10'h000;
  logic [3:0] hostClockOut, pciClockOut;
  logic [9:0] memClockOut;
  logic [1:0] agpClockOut;
  int edges[10] = '{default: 0}, base[10], mismatches = 0, checks = 0, cyc = 0;
  int hostK[8] = '{60000, 66800, 68500, 75000, 75000, 83300, 90000, 100000};
  int pciK[8] = '{30000, 33400, 34250, 37500, 32000, 33300, 30000, 33300};
  int agpK[8] = '{60000, 66800, 68500, 75000, 64000, 66600, 60000, 66600};
  int fastK[8] = '{112000, 66800, 124000, 75000, 133300, 83300, 95250, 100200};
  always #2.5 ref_clk = ~ref_clk;
  scs_clock_select #(.FAST_VARIANT(0)) i_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr,
    .freqSelectBit0PinIn(pinIn[0]), .freqSelectBit0PinOut(pinOut[0]),
    .freqSelectBit0PinOe_n(pinOe_n[0]), .freqSelectBit1PinIn(pinIn[1]),
    .freqSelectBit1PinOut(pinOut[1]), .freqSelectBit1PinOe_n(pinOe_n[1]),
    .freqSelectBit2PinIn(pinIn[2]), .freqSelectBit2PinOut(pinOut[2]),
    .freqSelectBit2PinOe_n(pinOe_n[2]), .refVoltPinIn(pinIn[3]), .refVoltPinOut(pinOut[3]),
    .refVoltPinOe_n(pinOe_n[3]), .modePinIn(pinIn[4]), .modePinOut(pinOut[4]),
    .modePinOe_n(pinOe_n[4]), .memHostStopPinIn(pinIn[5]), .memHostStopPinOut(pinOut[5]),
    .memHostStopPinOe_n(pinOe_n[5]), .memPciStopPinIn(pinIn[6]),
    .memPciStopPinOut(pinOut[6]), .memPciStopPinOe_n(pinOe_n[6]), .hostClockOut,
    .memClockOut, .agpClockOut, .pciClockOut, .referenceClockOut1, .hostBufferVoltageSelect);
  scs_load_model i_load (.pinOut, .pinOe_n, .level, .pinIn);
  // Fast table variant on the same straps, watched through its frequency register
  scs_clock_select #(.FAST_VARIANT(1)) i_dutFast (.ref_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata(prdataFast), .pready(), .pslverr(),
    .freqSelectBit0PinIn(pinIn[0]), .freqSelectBit0PinOut(), .freqSelectBit0PinOe_n(),
    .freqSelectBit1PinIn(pinIn[1]), .freqSelectBit1PinOut(), .freqSelectBit1PinOe_n(),
    .freqSelectBit2PinIn(pinIn[2]), .freqSelectBit2PinOut(), .freqSelectBit2PinOe_n(),
    .refVoltPinIn(pinIn[3]), .refVoltPinOut(), .refVoltPinOe_n(), .modePinIn(pinIn[4]),
    .modePinOut(), .modePinOe_n(), .memHostStopPinIn(pinIn[5]), .memHostStopPinOut(),
    .memHostStopPinOe_n(), .memPciStopPinIn(pinIn[6]), .memPciStopPinOut(),
    .memPciStopPinOe_n(), .hostClockOut(), .memClockOut(), .agpClockOut(), .pciClockOut(),
    .referenceClockOut1(), .hostBufferVoltageSelect());
  // --------------------------------------------------------------
  // Rising-edge counters per watched clock
  // --------------------------------------------------------------
  assign smp = {pinOut[3], pinOut[4], pinOut[0], pinOut[5], pinOut[1], referenceClockOut1,
    pciClockOut[0], agpClockOut[0], memClockOut[0], hostClockOut[0]};
  always @(posedge ref_clk) begin
    smpPrev <= smp;
    cyc <= cyc + 1;
    for (int i = 0; i < 10; i++) begin
      if (smp[i] === 1'b1 && smpPrev[i] === 1'b0) edges[i] <= edges[i] + 1;
    end
    if (cyc == 30000) begin
      mismatches++;
      finish_test;
    end
  end
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int d(input int i);
    return edges[i] - base[i];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol = 0);
    checks++;
    if ((tol == 0 && got !== exp) || ^got === 1'bx || got > exp + tol || got + tol < exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd = 32'h0);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1);
    chk(n, 1);
    rd = prdata;
    rdFast = prdataFast;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic strapReset(input logic [2:0] code, input logic mode, input logic volt);
    level <= {2'b11, mode, volt, code};
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic meas(input int n);
    base = edges;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    logic [6:0] r;
    for (int c = 0; c < 8; c++) begin
      r = 7'(rnd());
      strapReset(3'(c), 1'b1, r[0]);
      // Strap levels flip after the latch; the latched set must not follow
      level <= ~level;
      meas(2000);
      chk(d(0), hostK[c] / 100, 1);
      chk(d(1), hostK[c] / 100, 1);
      chk(d(6), hostK[c] / 100, 1);
      chk(d(2), agpK[c] / 100, 1);
      chk(d(3), pciK[c] / 100, 1);
      chk(d(5), pciK[c] / 100, 1);
      chk(d(4), 143, 1);
      chk(d(9), 143, 1);
      apb(1'b0, `SCS_OFS_STATUS);
      chk(rd[5:0], {1'b1, r[0], 1'b1, 3'(c)});
      chk(hostBufferVoltageSelect, r[0]);
      apb(1'b0, `SCS_OFS_FREQ);
      chk(rd, hostK[c]);
      chk(rdFast, fastK[c]);
    end
    strapReset(3'h7, 1'b0, 1'b0);
    chk(pinOe_n[6:5], 2'b11);
    level[5] <= 1'b0;
    repeat (60) @(posedge ref_clk);
    meas(400);
    chk(d(0) + d(2), 0);
    chk(d(3), 66, 1);
    chk(d(6), 0);
    chk(d(7), 96, 1);
    chk(d(8), 48, 1);
    apb(1'b0, `SCS_OFS_STATUS);
    chk(rd[10:9], 2'b01);
    level[5] <= 1'b1;
    level[6] <= 1'b0;
    repeat (60) @(posedge ref_clk);
    meas(400);
    chk(d(0), 200, 1);
    chk(d(3), 0);
    chk(d(5), 66, 1);
    level[6] <= 1'b1;
    // Control register: reset value, read back, read-only and unmapped places
    apb(1'b0, `SCS_OFS_CTRL);
    chk(rd, 32'h0000007F);
    r = 7'(rnd());
    apb(1'b1, `SCS_OFS_CTRL, {25'h0, r});
    apb(1'b0, `SCS_OFS_CTRL);
    chk(rd, {25'h0, r});
    apb(1'b1, `SCS_OFS_STATUS, 32'hFFFFFFFF);
    chk(err, 1'b0);
    apb(1'b0, 12'h00C);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    finish_test;
  end
endmodule
bind scs_clock_select scs_clock_select_properties i_props (.ref_clk, .rst_n,
  .freqSelectBit0PinOe_n, .freqSelectBit1PinOe_n, .freqSelectBit2PinOe_n, .refVoltPinOe_n,
  .modePinOe_n, .freqSelectBit1PinOut, .freqSelectBit2PinOut, .refVoltPinIn,
  .memHostStopPinIn, .memHostStopPinOut, .memHostStopPinOe_n, .memPciStopPinIn,
  .memPciStopPinOut, .memPciStopPinOe_n, .hostClockOut, .agpClockOut, .pciClockOut,
  .hostBufferVoltageSelect);
